/* hdl/cixs_pkg.sv */
// package: encodings, field positions and reset values for the execute subset
//**********************************************************************
// Contract
// - invert register, dest select, zero flag only
// - dest bit 0 accumulator, 1 register
// - decrement, no flags, skip on zero
// - increment, no flags, skip on zero
// - skip flushes prefetched word, runs idle
// - jump loads eleven bits plus latch bits
// - increment into dest, update zero flag
// - or literal into accumulator, zero flag
// - or register with accumulator, zero flag
// - copy register to dest, zero flag
// - literal into accumulator, no flags
// - interrupt return pops, sets irq allow
// - literal to accumulator, pop, two cycles
// - subroutine return pops into counter
// - rotate right through carry, carry only
//**********************************************************************
package cixs_pkg;
   localparam int unsigned PC_W    = 13;
   localparam int unsigned STACK_D = 8;
   localparam int unsigned SP_W    = 3;
   localparam int unsigned DEST_BIT = 7;
   localparam int unsigned REG_LSB  = 0;
   localparam int unsigned REG_W    = 7;
   localparam int unsigned JMP_W    = 11;
   localparam int unsigned LATCH_HI = 4;
   localparam int unsigned LATCH_LO = 3;

   localparam logic [3:0]  OP_OR_REG  = 4'h4;
   localparam logic [3:0]  OP_COPY    = 4'h8;
   localparam logic [3:0]  OP_INVERT  = 4'h9;
   localparam logic [3:0]  OP_INC     = 4'ha;
   localparam logic [3:0]  OP_DEC_SKZ = 4'hb;
   localparam logic [3:0]  OP_ROTR    = 4'hc;
   localparam logic [3:0]  OP_INC_SKZ = 4'hf;
   localparam logic [3:0]  OP_OR_IMM  = 4'h8;
   localparam logic [13:0] ENC_RET    = 14'h0008;
   localparam logic [13:0] ENC_IRET   = 14'h0009;
   localparam logic [13:0] ENC_CFG    = 14'h0062;
   localparam logic [13:0] ENC_IDLE   = 14'h0000;

   localparam logic [PC_W-1:0] PC_RST  = 13'h0000;
   localparam logic [7:0]      ACC_RST = 8'h00;
   localparam logic [7:0]      CFG_RST = 8'hff;

   typedef struct packed {
      logic       wr;
      logic [6:0] addr;
      logic [7:0] data;
   } cixs_wr_t;

   typedef struct packed {
      logic        valid;
      logic [13:0] word;
   } cixs_fetch_t;
endpackage

/* hdl/cixs_stack.sv */
// file: eight-level return address stack
module cixs_stack
   import cixs_pkg::*;
(
   input  wire logic            i_clk,
   input  wire logic            i_reset_n,
   input  wire logic            i_push,
   input  wire logic [PC_W-1:0] i_push_addr,
   input  wire logic            i_pop,
   output logic      [PC_W-1:0] o_stack_top
);
   logic [PC_W-1:0] slot [STACK_D];
   logic [SP_W-1:0] sp;

   // circular: overflow silently overwrites the oldest entry
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sp <= '0;
      end else if (i_push) begin
         sp <= sp + 3'h1;
      end else if (i_pop) begin
         sp <= sp - 3'h1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_push) begin
         slot[sp] <= i_push_addr;
      end
   end

   assign o_stack_top = slot[sp - 3'h1];
endmodule // cixs_stack

/* hdl/cixs_core.sv */
// file: execute stage for the instruction subset
module cixs_core
   import cixs_pkg::*;
(
   input  wire logic            i_clk,
   input  wire logic            i_reset_n,
   input  wire cixs_fetch_t     i_fetch,
   input  wire logic [7:0]      i_reg_rdata,
   input  wire logic [4:0]      i_upper_jump_latch,
   input  wire logic            i_push,
   input  wire logic [PC_W-1:0] i_push_addr,
   output logic      [6:0]      o_reg_raddr,
   output cixs_wr_t             o_reg_wr,
   output logic      [7:0]      o_accum,
   output logic      [PC_W-1:0] o_program_counter,
   output logic                 o_zero,
   output logic                 o_carry,
   output logic                 o_global_irq_allow,
   output logic      [7:0]      o_prescale_cfg,
   output logic                 o_flush
);
   //*******************************************************************
   // decode
   //*******************************************************************
   logic [13:0]     ir;
   logic [3:0]      op;
   logic            dest_reg;
   logic [7:0]      f;
   logic [7:0]      lit;
   logic [7:0]      res;
   logic            wr_res;
   logic            upd_z;
   logic            upd_c;
   logic            skip;
   logic            branch;
   logic            pop;
   logic            exec;
   logic [PC_W-1:0] stack_top;
   logic [PC_W-1:0] next_pc;
   logic [7:0]      rot;

   assign exec     = i_fetch.valid && !o_flush;
   assign ir       = exec ? i_fetch.word : ENC_IDLE;
   assign op       = ir[11:8];
   assign dest_reg = ir[DEST_BIT];
   assign f        = i_reg_rdata;
   assign lit      = ir[7:0];
   assign rot      = {o_carry, f[7:1]};

   always_comb begin
      res    = o_accum;
      wr_res = 1'b0;
      upd_z  = 1'b0;
      upd_c  = 1'b0;
      skip   = 1'b0;
      branch = 1'b0;
      pop    = 1'b0;
      unique casez (ir[13:12])
         2'b00: begin
            if (ir == ENC_RET || ir == ENC_IRET) begin
               pop    = 1'b1;
               branch = 1'b1;
            end else if (op == 4'h0 && ir[7]) begin
               res    = o_accum;
               wr_res = 1'b1;
            end else begin
               case (op)
                  OP_INVERT: begin res = ~f; wr_res = 1'b1; upd_z = 1'b1; end
                  OP_INC: begin res = f + 8'h01; wr_res = 1'b1; upd_z = 1'b1; end
                  OP_OR_REG: begin res = o_accum | f; wr_res = 1'b1; upd_z = 1'b1; end
                  OP_COPY: begin res = f; wr_res = 1'b1; upd_z = 1'b1; end
                  OP_ROTR: begin res = rot; wr_res = 1'b1; upd_c = 1'b1; end
                  OP_DEC_SKZ: begin
                     res    = f - 8'h01;
                     wr_res = 1'b1;
                     skip   = (res == 8'h00);
                  end
                  OP_INC_SKZ: begin
                     res    = f + 8'h01;
                     wr_res = 1'b1;
                     skip   = (res == 8'h00);
                  end
                  default: begin
                     res = o_accum;
                  end
               endcase
            end
         end
         2'b10: begin
            branch = ir[11];
         end
         2'b11: begin
            if (ir[11:10] == 2'b00) begin
               res = lit;
            end else if (ir[11:10] == 2'b01) begin
               res    = lit;
               pop    = 1'b1;
               branch = 1'b1;
            end else if (op == OP_OR_IMM) begin
               res   = o_accum | lit;
               upd_z = 1'b1;
            end
         end
         default: begin
            res = o_accum;
         end
      endcase
   end

   cixs_stack u_stack (
      .i_clk       (i_clk),
      .i_reset_n   (i_reset_n),
      .i_push      (i_push),
      .i_push_addr (i_push_addr),
      .i_pop       (pop),
      .o_stack_top (stack_top)
   );

   always_comb begin
      next_pc = o_program_counter + 13'h0001;
      if (pop) begin
         next_pc = stack_top;
      end else if (branch) begin
         next_pc = {i_upper_jump_latch[LATCH_HI:LATCH_LO], ir[JMP_W-1:0]};
      end
   end

   //*******************************************************************
   // state
   //*******************************************************************
   assign o_reg_raddr = i_fetch.word[REG_W-1:REG_LSB];

   // a taken branch or skip costs one extra cycle spent as idle
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_flush <= 1'b0;
      end else begin
         o_flush <= exec && (skip || branch);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_program_counter <= PC_RST;
      end else if (i_fetch.valid || o_flush) begin
         o_program_counter <= next_pc;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_accum  <= ACC_RST;
         o_reg_wr <= '0;
      end else begin
         o_reg_wr <= '0;
         if (wr_res && (dest_reg || op == 4'h0)) begin
            o_reg_wr <= '{wr: 1'b1, addr: ir[REG_W-1:REG_LSB], data: res};
         end else if (ir[13:12] == 2'b11 || wr_res) begin
            o_accum <= res;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_zero  <= 1'b0;
         o_carry <= 1'b0;
      end else begin
         if (upd_z) begin
            o_zero <= (res == 8'h00);
         end
         if (upd_c) begin
            o_carry <= f[0];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         o_global_irq_allow <= 1'b0;
         o_prescale_cfg     <= CFG_RST;
      end else begin
         if (ir == ENC_IRET) begin
            o_global_irq_allow <= 1'b1;
         end
         if (ir == ENC_CFG) begin
            o_prescale_cfg <= o_accum;
         end
      end
   end
endmodule // cixs_core

/* test/cixs_core_asserts.sv */
// checker: port-level properties of the execute stage
module cixs_core_chk
   import cixs_pkg::*;
(
   input wire logic            i_clk,
   input wire logic            i_reset_n,
   input wire cixs_fetch_t     i_fetch,
   input wire logic [7:0]      i_reg_rdata,
   input wire logic [4:0]      i_upper_jump_latch,
   input wire cixs_wr_t        o_reg_wr,
   input wire logic [7:0]      o_accum,
   input wire logic [PC_W-1:0] o_program_counter,
   input wire logic            o_zero,
   input wire logic            o_carry,
   input wire logic            o_global_irq_allow,
   input wire logic [7:0]      o_prescale_cfg,
   input wire logic            o_flush
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic        tk = i_fetch.valid && !o_flush;
   wire logic [13:0] w  = i_fetch.word;
   a_jump_target: assert property (tk && w[13:11] == 3'b101 |=> o_flush && o_program_counter ==
      {$past(i_upper_jump_latch[4:3]), $past(w[10:0])}) else $error("jump target");
   a_dec_skip: assert property (tk && w[13:8] == 6'h0b && i_reg_rdata == 8'h01
      |=> o_flush && $stable(o_zero)) else $error("dec skip");
   a_inc_skip: assert property (tk && w[13:8] == 6'h0f && i_reg_rdata == 8'hff
      |=> o_flush) else $error("inc skip");
   a_store_acc: assert property (tk && w[13:7] == 7'h01 |=> o_reg_wr ==
      {1'b1, $past(w[6:0]), $past(o_accum)} && $stable({o_zero, o_carry})) else $error("store");
   a_or_imm: assert property (tk && w[13:8] == 6'h38 |=> o_accum == $past(o_accum | w[7:0])
      && o_zero == (o_accum == 8'h00)) else $error("or literal");
   a_invert_reg: assert property (tk && w[13:7] == 7'h13 |=> o_reg_wr.wr
      && o_reg_wr.data == ~$past(i_reg_rdata)) else $error("invert");
   a_irq_return: assert property (tk && w == ENC_IRET |=> o_global_irq_allow && o_flush)
      else $error("irq return");
   a_cfg_load: assert property (tk && w == ENC_CFG |=> o_prescale_cfg == $past(o_accum))
      else $error("cfg load");
   a_refuse_word: assert property (o_flush |=> !o_reg_wr.wr && $stable(o_accum))
      else $error("refused word ran");
   a_load_imm: assert property (tk && w[13:10] == 4'hc |=> o_accum == $past(w[7:0])
      && $stable(o_zero)) else $error("load literal");
   c_ret: cover property (tk && w == ENC_RET);
   c_jump: cover property (tk && w[13:11] == 3'b101);
   c_skip: cover property (tk && w[13:8] == 6'h0b && i_reg_rdata == 8'h01);
endmodule // cixs_core_chk
bind cixs_core cixs_core_chk u_chk (.i_clk, .i_reset_n, .i_fetch, .i_reg_rdata,
   .i_upper_jump_latch, .o_reg_wr, .o_accum, .o_program_counter, .o_zero, .o_carry,
   .o_global_irq_allow, .o_prescale_cfg, .o_flush);

/* test/tb.sv */
// testbench: self-checking run of the execute stage
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cixs_pkg::*;
   logic            i_clk, i_reset_n, i_push, o_zero, o_carry, o_global_irq_allow, o_flush;
   cixs_fetch_t     i_fetch;
   cixs_wr_t        o_reg_wr;
   logic [7:0]      i_reg_rdata, o_accum, o_prescale_cfg, acc, cfg;
   logic [6:0]      o_reg_raddr;
   logic [4:0]      i_upper_jump_latch;
   logic [PC_W-1:0] i_push_addr, o_program_counter, pc, stk[$];
   logic            z, c, global_irq_allow, fl;
   logic [48:0]     exp_q[$];
   int              n_errors, samples_checked, seed;
   logic [7:0]      rds[4] = '{8'h00, 8'h01, 8'hff, 8'h5a};
   logic [3:0]      codes[7] = '{OP_OR_REG, OP_COPY, OP_INVERT, OP_INC, OP_DEC_SKZ, OP_ROTR,
                                 OP_INC_SKZ};
   logic [13:0]     rets[3] = '{ENC_RET, 14'h34a5, ENC_IRET};
   cixs_core uut (.i_clk, .i_reset_n, .i_fetch, .i_reg_rdata, .i_upper_jump_latch, .i_push,
      .i_push_addr, .o_reg_raddr, .o_reg_wr, .o_accum, .o_program_counter, .o_zero, .o_carry,
      .o_global_irq_allow, .o_prescale_cfg, .o_flush);
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   //****************************************
   // driver: notes the expected state
   //****************************************
   task automatic op(input logic [13:0] w, input logic [7:0] rd);
      logic [7:0] r;
      logic       zu, rr, nf;
      cixs_wr_t   wr;
      i_fetch = {1'b1, w};
      i_reg_rdata = rd;
      {r, zu, rr, nf} = {acc, 3'b000};
      wr = '0;
      pc = pc + 1'b1;
      if (!fl) begin
         casez (w)
            ENC_RET: nf = 1'b1;
            ENC_IRET: {global_irq_allow, nf} = 2'b11;
            ENC_CFG: cfg = acc;
            14'b00_0000_1???????: wr = '{1'b1, w[6:0], acc};
            14'b00_0100_????????: {r, zu, rr, nf} = {acc | rd, 3'b110};
            14'b00_1000_????????: {r, zu, rr, nf} = {rd, 3'b110};
            14'b00_1001_????????: {r, zu, rr, nf} = {~rd, 3'b110};
            14'b00_1010_????????: {r, zu, rr, nf} = {rd + 8'h01, 3'b110};
            14'b00_1011_????????: {r, zu, rr, nf} = {rd - 8'h01, 2'b01, rd == 8'h01};
            14'b00_1100_????????: {r, zu, rr, nf, c} = {c, rd[7:1], 3'b010, rd[0]};
            14'b00_1111_????????: {r, zu, rr, nf} = {rd + 8'h01, 2'b01, rd == 8'hff};
            14'b11_00??_????????: {r, zu, rr, nf} = {w[7:0], 3'b000};
            14'b11_01??_????????: {r, zu, rr, nf} = {w[7:0], 3'b001};
            14'b11_1000_????????: {r, zu, rr, nf} = {acc | w[7:0], 3'b100};
            14'b10_1???_????????: {pc, nf} = {i_upper_jump_latch[4:3], w[10:0], 1'b1};
            default: ;
         endcase
         if (nf && (w[13:12] == 2'b11 || w[13:4] == 10'h000))
            pc = stk.pop_back();
         if (zu)
            z = r == 8'h00;
         if (rr && w[7])
            wr = '{1'b1, w[6:0], r};
         else
            acc = r;
      end
      fl = nf;
      @(posedge i_clk);
      // noted only once the word is taken, so the watcher never runs a cycle ahead
      exp_q.push_back({nf, pc, global_irq_allow, cfg, z, c, acc, wr});
      samples_checked++;
      if (o_reg_raddr !== w[6:0]) begin
         n_errors++;
         $display("BAD reg_raddr exp %h got %h", w[6:0], o_reg_raddr);
      end
      #1;
   endtask
   always @(posedge i_clk) begin
      logic [48:0] e, g;
      #2;
      if (exp_q.size() > 0) begin
         e = exp_q.pop_front();
         g = {o_flush, o_program_counter, o_global_irq_allow, o_prescale_cfg, o_zero, o_carry,
              o_accum, o_reg_wr.wr ? o_reg_wr : 16'h0000};
         samples_checked++;
         if (g !== e) begin
            n_errors++;
            $display("BAD state exp %h got %h", e, g);
         end
      end
   end
   task automatic complete_run();
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #20000;
      n_errors++;
      complete_run();
   end
   initial begin
      seed = 82;
      {i_fetch, i_reg_rdata, i_push, i_push_addr, i_reset_n} = '0;
      i_upper_jump_latch = 5'($random(seed));
      {n_errors, samples_checked} = '0;
      {pc, acc, cfg, z, c, global_irq_allow, fl} = {PC_RST, ACC_RST, CFG_RST, 4'h0};
      rds[3] = 8'($random(seed));
      repeat (20) @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      op(14'h3300 | 14'(8'($random(seed))), 8'h00);
      op(14'h0085, 8'h00);
      foreach (rds[i])
         foreach (codes[j])
            op({2'b00, codes[j], 1'($random(seed)), 7'($random(seed))}, rds[i]);
      op({6'h38, 8'($random(seed))}, 8'h00);
      op({3'b101, 11'($random(seed))}, 8'h00);
      op(14'h0085, 8'h00);
      op(ENC_IDLE, 8'h00);
      for (int k = 0; k < 3; k++) begin
         i_push = 1'b1;
         i_push_addr = 13'($random(seed));
         stk.push_back(i_push_addr);
         op(ENC_IDLE, 8'h00);
         i_push = 1'b0;
         op(rets[k], 8'h00);
         op(ENC_IDLE, 8'h00);
         op(ENC_CFG, 8'h00);
      end
      #2;
      complete_run();
   end
endmodule // tb
